// >>> verilog/timer_prescaler_cfg.sv
// timer configuration register, 8-bit timer, pin logic and apb slave
`timescale 1ns/1ps
module timer_prescaler_cfg
    import timer_cfg_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PINS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_ext_clock_pin,
    input wire logic ext_irq_pin,
    input wire logic wdt_base_tick,
    output logic [PINS-1:0] pullup_en,
    output logic [7:0] timer_count,
    output logic timer_overflow,
    output logic watchdog_tick,
    output logic ext_irq_flag
);
    logic [7:0] cfg_r;
    logic [PINS-1:0] per_pin_pullup_enables_r;
    logic [PINS-1:0] pullup_en_r;
    logic [7:0] timer_count_r;
    logic ovf_r;
    logic wdt_tick_r;
    logic irq_flag_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [1:0] instr_cnt_r;
    logic tck_s1_r, tck_s2_r, tck_prev_r;
    logic irq_s1_r, irq_s2_r, irq_prev_r;

    presc_if pif ();

    // apb decode; access takes two cycles so read data are a flop
    logic access, fire, wr_fire;
    logic hit_cfg, hit_pullup, hit_timer, hit_status, unmapped;
    logic [31:0] prdata_nxt;
    assign access = psel & penable & ~pready_r;
    assign fire = psel & penable & pready_r;
    assign wr_fire = fire & pwrite;
    assign hit_cfg = (paddr == CFG_OFS);
    assign hit_pullup = (paddr == PULLUP_OFS);
    assign hit_timer = (paddr == TIMER_OFS);
    assign hit_status = (paddr == STATUS_OFS);
    assign unmapped = ~(hit_cfg | hit_pullup | hit_timer | hit_status);

    // read mux, upper bits read as zero
    assign prdata_nxt = hit_cfg ? {24'h000000, cfg_r} :
                        hit_pullup ? 32'(per_pin_pullup_enables_r) :
                        hit_timer ? {24'h000000, timer_count_r} :
                        hit_status ? {31'h00000000, irq_flag_r} : 32'h00000000;

    // named configuration fields
    logic pullup_dis, ext_irq_edge_sel, timer_clock_src_sel, timer_count_edge_sel, prescaler_assign;
    logic [2:0] prescale_rate_sel;
    assign pullup_dis = cfg_r[PULLUP_DIS_BIT];
    assign ext_irq_edge_sel = cfg_r[IRQ_EDGE_BIT];
    assign timer_clock_src_sel = cfg_r[CLK_SRC_BIT];
    assign timer_count_edge_sel = cfg_r[CNT_EDGE_BIT];
    assign prescaler_assign = cfg_r[ASSIGN_BIT];
    assign prescale_rate_sel = cfg_r[RATE_LSB +: RATE_W];

    // edges are seen on the second sync stage against a third, never on the first
    logic tck_rise, tck_fall, irq_rise, irq_fall, ext_edge, irq_event;
    assign tck_rise = tck_s2_r & ~tck_prev_r;
    assign tck_fall = ~tck_s2_r & tck_prev_r;
    assign irq_rise = irq_s2_r & ~irq_prev_r;
    assign irq_fall = ~irq_s2_r & irq_prev_r;
    assign ext_edge = timer_count_edge_sel ? tck_fall : tck_rise;
    assign irq_event = ext_irq_edge_sel ? irq_rise : irq_fall;

    // timer source and prescaler hookup
    logic instr_tick, timer_src_tick, timer_inc, cfg_write, presc_clear, timer_write, irq_clr;
    assign instr_tick = (instr_cnt_r == INSTR_LAST);
    assign timer_src_tick = timer_clock_src_sel ? ext_edge : instr_tick;
    assign pif.src_tick = prescaler_assign ? wdt_base_tick : timer_src_tick;
    assign pif.rate = prescale_rate_sel;
    assign pif.assign_wdt = prescaler_assign;
    assign timer_inc = prescaler_assign ? timer_src_tick : pif.div_tick;
    assign cfg_write = wr_fire & hit_cfg;
    // only a change of assignment or rate restarts the prescaler phase
    assign presc_clear = cfg_write & (pwdata[3:0] != cfg_r[3:0]);
    assign pif.clear = presc_clear;
    assign timer_write = wr_fire & hit_timer;
    assign irq_clr = wr_fire & hit_status & pwdata[IRQ_FLAG_BIT];

    shared_prescaler #(.CNT_W(8)) u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .p(pif)
    );

    // apb handshake and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= access;
            pslverr_r <= access & unmapped;
            prdata_r <= access ? prdata_nxt : prdata_r;
        end
    end

    // software registers; unmapped writes are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RESET;
            per_pin_pullup_enables_r <= PINS'(PULLUP_RESET);
        end else begin
            cfg_r <= cfg_write ? pwdata[7:0] : cfg_r;
            per_pin_pullup_enables_r <= (wr_fire & hit_pullup) ? pwdata[PINS-1:0] : per_pin_pullup_enables_r;
        end
    end

    // two-flop synchronisers plus an edge-history stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tck_s1_r, tck_s2_r, tck_prev_r} <= 3'h0;
            {irq_s1_r, irq_s2_r, irq_prev_r} <= 3'h0;
        end else begin
            {tck_s1_r, tck_s2_r, tck_prev_r} <= {timer_ext_clock_pin, tck_s1_r, tck_s2_r};
            {irq_s1_r, irq_s2_r, irq_prev_r} <= {ext_irq_pin, irq_s1_r, irq_s2_r};
        end
    end

    // instruction clock divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_cnt_r <= 2'h0;
        end else begin
            instr_cnt_r <= instr_tick ? 2'h0 : 2'(instr_cnt_r + 2'h1);
        end
    end

    // timer count; a software write wins over an increment in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_r <= TIMER_RESET;
            ovf_r <= 1'b0;
        end else begin
            timer_count_r <= timer_write ? pwdata[7:0] : (timer_inc ? 8'(timer_count_r + 8'h01) : timer_count_r);
            ovf_r <= ~timer_write & timer_inc & (timer_count_r == 8'hFF);
        end
    end

    // pin side outputs; set beats clear on the interrupt flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_en_r <= '0;
            wdt_tick_r <= 1'b0;
            irq_flag_r <= 1'b0;
        end else begin
            pullup_en_r <= pullup_dis ? '0 : per_pin_pullup_enables_r;
            wdt_tick_r <= prescaler_assign ? pif.div_tick : wdt_base_tick;
            irq_flag_r <= irq_event | (irq_flag_r & ~irq_clr);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pullup_en = pullup_en_r;
    assign timer_count = timer_count_r;
    assign timer_overflow = ovf_r;
    assign watchdog_tick = wdt_tick_r;
    assign ext_irq_flag = irq_flag_r;

    property p_cfg_write;
        @(posedge pclk) disable iff (!presetn)
        cfg_write |=> cfg_r == $past(pwdata[7:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_cfg_readback;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit_cfg) |=> prdata_r == {24'h000000, cfg_r};
    endproperty
    a_cfg_readback: assert property (p_cfg_readback) else $error("config read wrong");

    property p_pullup_off;
        @(posedge pclk) disable iff (!presetn)
        pullup_dis |=> pullup_en_r == '0;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-ups not disabled");

    property p_pullup_follow;
        @(posedge pclk) disable iff (!presetn)
        !pullup_dis |=> pullup_en_r == $past(per_pin_pullup_enables_r);
    endproperty
    a_pullup_follow: assert property (p_pullup_follow) else $error("pull-ups ignore enables");

    property p_irq_edge;
        @(posedge pclk) disable iff (!presetn)
        ((ext_irq_edge_sel && irq_rise) || (!ext_irq_edge_sel && irq_fall)) |=> irq_flag_r;
    endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("interrupt edge not flagged");

    property p_irq_wrong_edge;
        @(posedge pclk) disable iff (!presetn)
        (!irq_flag_r && !irq_event) |=> !irq_flag_r;
    endproperty
    a_irq_wrong_edge: assert property (p_irq_wrong_edge) else $error("flag set without edge");

    property p_instr_count;
        @(posedge pclk) disable iff (!presetn)
        (!timer_clock_src_sel && prescaler_assign && instr_tick && !timer_write && !cfg_write)
            |=> timer_count_r == 8'($past(timer_count_r) + 8'h01);
    endproperty
    a_instr_count: assert property (p_instr_count) else $error("timer missed instruction tick");

    property p_ext_edge_count;
        @(posedge pclk) disable iff (!presetn)
        (timer_clock_src_sel && prescaler_assign && !timer_write && !cfg_write
            && (timer_count_edge_sel ? tck_fall : tck_rise))
            |=> timer_count_r == 8'($past(timer_count_r) + 8'h01);
    endproperty
    a_ext_edge_count: assert property (p_ext_edge_count) else $error("timer missed pin edge");

    property p_wdt_route;
        @(posedge pclk) disable iff (!presetn)
        !prescaler_assign |=> watchdog_tick == $past(wdt_base_tick);
    endproperty
    a_wdt_route: assert property (p_wdt_route) else $error("watchdog routing wrong");

    // a changed setting must kill any divided tick already in flight
    property p_presc_clear;
        @(posedge pclk) disable iff (!presetn)
        (cfg_write && pwdata[3:0] != cfg_r[3:0]) |=> !pif.div_tick;
    endproperty
    a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared on change");
endmodule // timer_prescaler_cfg

// >>> verilog/timer_cfg_pkg.sv
// shared constants for the timer configuration and prescaler block
package timer_cfg_pkg;
    // register byte offsets on the apb bus
    localparam logic [11:0] CFG_OFS = 12'h000;
    localparam logic [11:0] PULLUP_OFS = 12'h004;
    localparam logic [11:0] TIMER_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00C;
    // values after reset
    localparam logic [7:0] CFG_RESET = 8'hFF;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [7:0] TIMER_RESET = 8'h00;
    // field positions in the configuration register
    localparam int PULLUP_DIS_BIT = 7;
    localparam int IRQ_EDGE_BIT = 6;
    localparam int CLK_SRC_BIT = 5;
    localparam int CNT_EDGE_BIT = 4;
    localparam int ASSIGN_BIT = 3;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    // status register field
    localparam int IRQ_FLAG_BIT = 0;
    // instruction clock is the oscillator divided by this count
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
endpackage

// >>> verilog/presc_if.sv
// carrier between the timer block and its shared prescaler
`timescale 1ns/1ps
interface presc_if;
    logic src_tick;
    logic [2:0] rate;
    logic assign_wdt;
    logic clear;
    logic div_tick;
    modport ctl (output src_tick, output rate, output assign_wdt, output clear, input div_tick);
    modport presc (input src_tick, input rate, input assign_wdt, input clear, output div_tick);
endinterface // presc_if

// >>> verilog/shared_prescaler.sv
// shared power-of-two prescaler serving either the timer or the watchdog
`timescale 1ns/1ps
module shared_prescaler
    import timer_cfg_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    presc_if.presc p
);
    logic [CNT_W-1:0] cnt_r;
    logic div_r;
    logic [3:0] shift;
    logic [CNT_W-1:0] mask;
    logic hit;

    // timer gets one extra halving so code 0 is 1:2, watchdog code 0 is 1:1
    assign shift = p.assign_wdt ? {1'b0, p.rate} : 4'({1'b0, p.rate} + 4'h1);
    genvar i;
    generate
        for (i = 0; i < CNT_W; i++) begin : g_mask
            assign mask[i] = (4'(i) < shift);
        end
    endgenerate
    assign hit = ((cnt_r & mask) == mask);
    assign p.div_tick = div_r;

    // free-running count; cleared on a setting change so no stale phase leaks out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            div_r <= 1'b0;
        end else if (p.clear) begin
            cnt_r <= '0;
            div_r <= 1'b0;
        end else begin
            cnt_r <= p.src_tick ? CNT_W'(cnt_r + 1'b1) : cnt_r;
            div_r <= p.src_tick & hit;
        end
    end

    property p_timer_ratio;
        @(posedge pclk) disable iff (!presetn)
        (p.src_tick && !p.clear && !p.assign_wdt && ((cnt_r & mask) == mask)) |=> div_r;
    endproperty
    a_timer_ratio: assert property (p_timer_ratio) else $error("timer prescale tick missing");

    property p_timer_no_undivided;
        @(posedge pclk) disable iff (!presetn)
        (p.src_tick && !p.clear && !p.assign_wdt && !cnt_r[0]) |=> !div_r;
    endproperty
    a_timer_no_undivided: assert property (p_timer_no_undivided) else $error("timer tick on even count");

    property p_wdt_one_to_one;
        @(posedge pclk) disable iff (!presetn)
        (p.src_tick && !p.clear && p.assign_wdt && p.rate == 3'h0) |=> div_r;
    endproperty
    a_wdt_one_to_one: assert property (p_wdt_one_to_one) else $error("watchdog 1:1 tick missing");

    property p_clear_count;
        @(posedge pclk) disable iff (!presetn)
        p.clear |=> (cnt_r == '0) && !div_r;
    endproperty
    a_clear_count: assert property (p_clear_count) else $error("prescaler not cleared");
endmodule // shared_prescaler

// >>> verif/ext_src_model.sv
// far-side model: timer clock pin source and watchdog timebase
`timescale 1ns/1ps
module ext_src_model #(
    parameter int WDT_GAP = 2,
    parameter int HALF = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic idle_lvl,
    output logic pin,
    output logic wdt_tick
);
    int ph;
    int wc;
    // pin toggles every HALF cycles while running, else rests at the bench level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 0;
            wc <= 0;
            pin <= 1'b0;
            wdt_tick <= 1'b0;
        end else begin
            wc <= (wc == WDT_GAP - 1) ? 0 : wc + 1;
            wdt_tick <= (wc == WDT_GAP - 1);
            ph <= (ph == HALF - 1) ? 0 : ph + 1;
            if (!run) begin
                pin <= idle_lvl;
            end else if (ph == HALF - 1) begin
                pin <= ~pin;
            end
        end
    end
endmodule // ext_src_model

// >>> verif/tb_timer_prescaler_cfg.sv
// self-checking bench for the timer configuration and prescaler block
`timescale 1ns/1ps
module tb_timer_prescaler_cfg;
    import timer_cfg_pkg::*;
    localparam int TO = 40000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic wtick;
    logic irq_pin = 1'b0;
    logic run = 1'b0;
    logic lvl = 1'b0;
    logic [7:0] pullup_en;
    logic [7:0] timer_count;
    logic timer_overflow;
    logic watchdog_tick;
    logic ext_irq_flag;
    logic [33:0] exp_q[$];
    logic [33:0] e_m;
    logic [31:0] v;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int wd_cnt = 0;
    int ov_cnt = 0;
    int o0;

    always #4 pclk = ~pclk;

    timer_prescaler_cfg u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_ext_clock_pin(pin), .ext_irq_pin(irq_pin), .wdt_base_tick(wtick),
        .pullup_en(pullup_en), .timer_count(timer_count), .timer_overflow(timer_overflow),
        .watchdog_tick(watchdog_tick), .ext_irq_flag(ext_irq_flag));
    ext_src_model u_src (.pclk(pclk), .presetn(presetn), .run(run), .idle_lvl(lvl), .pin(pin),
        .wdt_tick(wtick));

    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask

    task wrap_up();
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // e holds {is_read, expect_err, data}; the watcher below compares it
    // no local limit: only the bench timeout ends a stuck wait
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {2'b10, x});
    endtask

    // timer and watchdog progress over a window; watchdog skipped when xw < 0
    task span(input int n, input int xt, input int xw);
        logic [7:0] t0;
        int w0;
        @(posedge pclk);
        t0 = timer_count;
        w0 = wd_cnt;
        repeat (n) @(posedge pclk);
        chk("timer_delta", {24'h0, timer_count - t0}, 32'(xt & 255));
        if (xw >= 0) chk("wdt_delta", 32'(wd_cnt - w0), 32'(xw));
    endtask

    task irq_step(input logic l, input logic x);
        @(posedge pclk);
        irq_pin <= l;
        repeat (8) @(posedge pclk);
        chk("irq_flag", {31'h0, ext_irq_flag}, {31'h0, x});
    endtask

    // result watcher: pops the oldest note whenever a transfer completes
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e_m = exp_q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, e_m[32]});
            if (e_m[33]) chk("prdata", prdata, e_m[31:0]);
        end
        if (watchdog_tick === 1'b1) wd_cnt <= wd_cnt + 1;
        if (timer_overflow === 1'b1) ov_cnt <= ov_cnt + 1;
        cyc++;
        if (cyc == TO) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(56358));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CFG_OFS, 32'h000000FF);
        rd(PULLUP_OFS, 32'h0);
        rd(TIMER_OFS, 32'h0);
        apb(1'b0, 12'h010, 32'h0, {2'b11, 32'h0});
        apb(1'b1, 12'h010, 32'h0, {2'b01, 32'h0});
        v = $urandom;
        wr(CFG_OFS, v);
        rd(CFG_OFS, {24'h0, v[7:0]});
        // pull-ups follow per-pin enables only while the disable bit is low
        v = $urandom;
        wr(PULLUP_OFS, v);
        wr(CFG_OFS, 32'h00000058);
        repeat (3) @(posedge pclk);
        chk("pullup_on", {24'h0, pullup_en}, {24'h0, v[7:0]});
        wr(CFG_OFS, 32'h000000D8);
        repeat (3) @(posedge pclk);
        chk("pullup_off", {24'h0, pullup_en}, 32'h0);
        irq_step(1'b1, 1'b1);
        wr(STATUS_OFS, 32'h00000001);
        irq_step(1'b0, 1'b0);
        wr(CFG_OFS, 32'h00000098);
        irq_step(1'b1, 1'b0);
        irq_step(1'b0, 1'b1);
        rd(STATUS_OFS, 32'h00000001);
        // every rate code, prescaler on the timer, then on the watchdog
        for (int r = 0; r < 8; r++) begin
            wr(CFG_OFS, 32'h000000D0 | r);
            // setting changed, so the first divided tick needs a full fresh period
            @(posedge pclk);
            v[7:0] = timer_count;
            repeat ((1 << (r + 3)) - 4) @(posedge pclk);
            chk("presc_phase", {24'h0, timer_count - v[7:0]}, 32'h0);
            repeat (6) @(posedge pclk);
            chk("presc_first", {24'h0, timer_count - v[7:0]}, 32'h1);
            span(2 << (r + 3), 2, -1);
            wr(CFG_OFS, 32'h000000D8 | r);
            repeat ((2 << r) + 8) @(posedge pclk);
            span(8 << r, 2 << r, 4);
        end
        // single pin edges; the counted edge follows the edge select bit
        for (int s = 0; s < 2; s++) begin
            wr(CFG_OFS, s ? 32'h000000F8 : 32'h000000E8);
            repeat (8) @(posedge pclk);
            v[7:0] = timer_count;
            lvl <= 1'b1;
            repeat (10) @(posedge pclk);
            chk("edge_a", {24'h0, timer_count - v[7:0]}, s ? 32'h0 : 32'h1);
            lvl <= 1'b0;
            repeat (10) @(posedge pclk);
            chk("edge_b", {24'h0, timer_count - v[7:0]}, 32'h1);
        end
        // software load of the count, then one counted edge wraps it
        wr(TIMER_OFS, 32'h000000FF);
        rd(TIMER_OFS, 32'h000000FF);
        @(posedge pclk);
        o0 = ov_cnt;
        lvl <= 1'b1;
        repeat (10) @(posedge pclk);
        lvl <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("wrap_count", {24'h0, timer_count}, 32'h0);
        chk("overflow", 32'(ov_cnt - o0), 32'h1);
        run <= 1'b1;
        repeat (16) @(posedge pclk);
        span(80, 10, -1);
        run <= 1'b0;
        // a reset after the pin run stops restores the config to all ones
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CFG_OFS, 32'h000000FF);
        repeat (4) @(posedge pclk);
        wrap_up();
    end
endmodule // tb_timer_prescaler_cfg
